// *** rtl/adc_board_audio_router.sv ***
// Switch/host configuration and serial audio routing for the converter board.
`timescale 1ns/100ps
`include "audio_router_defs.svh"

module adc_board_audio_router (
  input  wire logic                   clk_sys,
  input  wire logic                   rst,
  input  wire logic [`SWA_WIDTH-1:0]  switch_bank_a,
  input  wire logic [`SWB_WIDTH-1:0]  switch_bank_b,
  input  wire logic                   host_ctrl_en,
  input  wire logic [1:0]             host_speed_mode_sel,
  input  wire logic [1:0]             host_format_sel,
  input  wire logic [1:0]             host_pair_sel,
  input  wire logic                   host_mclk_half_div,
  input  wire logic                   host_mclk_three_halves_div,
  input  wire logic                   adc_sclk,
  input  wire logic                   adc_lrck,
  input  wire logic [`LANES-1:0]      serial_out_lane,
  output      logic [1:0]             adc_speed_mode_sel,
  output      logic [1:0]             adc_format_sel,
  output      logic                   adc_mclk_half_div,
  output      logic                   adc_mclk_three_halves_div,
  output      logic [1:0]             tx_speed_mode_sel,
  output      logic                   tx_mclk_half_div,
  output      logic                   tx_mclk_three_halves_div,
  output      logic                   tx_lane_data,
  output      logic                   tx_valid,
  input  wire logic                   tx_ready,
  output      logic [`SAMPLE_BITS-1:0] tx_left,
  output      logic [`SAMPLE_BITS-1:0] tx_right,
  output      logic                   dsp_sclk,
  output      logic                   dsp_lrck,
  output      logic [`LANES-1:0]      dsp_data,
  output      logic                   frame_aligned,
  output      logic                   overrun
);

  localparam int SW_W  = `SWA_WIDTH + `SWB_WIDTH;
  localparam int PIN_W = 2 + `LANES;
  localparam int WORD_W = 2 * `SAMPLE_BITS;

  typedef struct packed {
    logic [SW_W-1:0]                sw_meta;
    logic [SW_W-1:0]                sw_sync;
    logic [PIN_W-1:0]               pin_meta;
    logic [PIN_W-1:0]               pin_sync;
    logic                           sclk_prev;
    logic                           lr_prev;
    audio_router_pkg::speed_mode_t  speed;
    audio_router_pkg::format_t      format;
    logic [1:0]                     pair;
    logic                           half_div;
    logic                           three_halves;
    logic [`BIT_CNT_W-1:0]          bit_cnt;
    logic [`SAMPLE_BITS-1:0]        shift;
    logic [`SAMPLE_BITS-1:0]        left;
    logic                           aligned;
    logic                           word_done;
    logic [WORD_W-1:0]              word;
    logic                           overrun;
    logic                           lane_data;
    logic [PIN_W-1:0]               dsp_pins;
  } router_state_t;

  router_state_t state;
  router_state_t next_state;
  logic          buf_in_ready;
  logic [WORD_W-1:0] buf_out_data;

  // True for the two time-division multiplexed formats.
  function automatic logic is_tdm(input audio_router_pkg::format_t f);
    return (f == audio_router_pkg::FORMAT_TDM_2WIRE) ||
           (f == audio_router_pkg::FORMAT_TDM_4WIRE);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Configuration and capture

  logic                      sclk_s;
  logic                      lrck_s;
  logic [`LANES-1:0]         lanes_s;
  logic                      sclk_rise;
  logic                      frame_edge;
  logic [`BIT_CNT_W-1:0]     pos;
  logic [`BIT_CNT_W-1:0]     pcm_bit;
  logic                      din;
  logic [`SAMPLE_BITS-1:0]   sample;
  logic [1:0]                sel_speed;
  logic [1:0]                sel_format;
  logic [1:0]                sel_pair;
  logic                      sel_half;
  logic                      sel_three;
  logic                      cfg_change;
  logic                      pcm_left;

  assign sclk_s  = state.pin_sync[PIN_W-1];
  assign lrck_s  = state.pin_sync[PIN_W-2];
  assign lanes_s = state.pin_sync[`LANES-1:0];

  always_comb begin
    next_state = state;
    next_state.word_done = 1'b0;
    next_state.overrun   = 1'b0;

    // Switches and pins pass two flops before any use.
    next_state.sw_meta  = {switch_bank_b, switch_bank_a};
    next_state.sw_sync  = state.sw_meta;
    next_state.pin_meta = {adc_sclk, adc_lrck, serial_out_lane};
    next_state.pin_sync = state.pin_meta;
    next_state.sclk_prev = sclk_s;
    next_state.dsp_pins  = state.pin_sync;

    if (host_ctrl_en) begin
      sel_speed  = host_speed_mode_sel;
      sel_format = host_format_sel;
      sel_pair   = host_pair_sel;
      sel_half   = host_mclk_half_div;
      sel_three  = host_mclk_three_halves_div;
    end else begin
      sel_speed  = state.sw_sync[`SWA_SPEED_HI:`SWA_SPEED_LO];
      sel_format = state.sw_sync[`SWA_FORMAT_HI:`SWA_FORMAT_LO];
      sel_pair   = state.sw_sync[`SWA_PAIR_HI:`SWA_PAIR_LO];
      sel_half   = state.sw_sync[`SWA_WIDTH + `SWB_HALF_DIV];
      sel_three  = state.sw_sync[`SWA_WIDTH + `SWB_THREE_HALVES];
    end
    next_state.speed        =
      audio_router_pkg::speed_mode_t'(sel_speed);
    next_state.format       = audio_router_pkg::format_t'(sel_format);
    next_state.pair         = sel_pair;
    next_state.half_div     = sel_half;
    next_state.three_halves = sel_three;
    cfg_change = (sel_format != state.format) || (sel_pair != state.pair);

    // Forward the selected lane straight through in every format, TDM included.
    next_state.lane_data = lanes_s[state.pair];

    sclk_rise = sclk_s && !state.sclk_prev;
    if (is_tdm(state.format)) begin
      frame_edge = lrck_s && !state.lr_prev;
      din        = lanes_s[0];
    end else begin
      frame_edge = lrck_s != state.lr_prev;
      din        = lanes_s[state.pair];
    end
    pos      = frame_edge ? '0 : state.bit_cnt + 1'b1;
    pcm_bit  = pos - ((state.format == audio_router_pkg::FORMAT_I2S) ?
                      `BIT_CNT_W'(1) : `BIT_CNT_W'(0));
    pcm_left = lrck_s ^ (state.format == audio_router_pkg::FORMAT_I2S);
    sample   = {state.shift[`SAMPLE_BITS-2:0], din};

    if (sclk_rise) begin
      next_state.lr_prev = lrck_s;
      next_state.bit_cnt = pos;
      if (frame_edge && (is_tdm(state.format) || pcm_left)) begin
        next_state.aligned = 1'b1;
      end
      if (is_tdm(state.format)) begin
        // Slot pos[7:5] belongs to the chosen pair when its upper bits match.
        if (pos[7:6] == state.pair &&
            pos[4:0] < 5'(`SAMPLE_BITS)) begin
          next_state.shift = sample;
          if (pos[4:0] == 5'(`SAMPLE_BITS - 1)) begin
            if (!pos[5]) begin
              next_state.left = sample;
            end else begin
              next_state.word = {state.left, sample};
              next_state.word_done = state.aligned;
            end
          end
        end
      end else if (pcm_bit < `BIT_CNT_W'(`SAMPLE_BITS)) begin
        next_state.shift = sample;
        if (pcm_bit == `BIT_CNT_W'(`SAMPLE_BITS - 1)) begin
          if (pcm_left) begin
            next_state.left = sample;
          end else begin
            next_state.word = {state.left, sample};
            next_state.word_done = state.aligned;
          end
        end
      end
    end

    // A format or pair change drops alignment until the next frame start.
    if (cfg_change) begin
      next_state.aligned   = 1'b0;
      next_state.word_done = 1'b0;
    end
    // The converter cannot be stalled, so a full buffer loses the word.
    if (state.word_done && !buf_in_ready) begin
      next_state.overrun = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state        <= '0;
      state.speed  <= audio_router_pkg::speed_mode_t'(`RST_SPEED);
      state.format <= audio_router_pkg::format_t'(`RST_FORMAT);
      state.pair   <= `RST_PAIR;
    end else begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Word buffer toward the transmitter

  two_entry_buffer #(
    .WIDTH (WORD_W),
    .DEPTH (`BUF_DEPTH)
  ) u_word_buffer (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .in_valid  (state.word_done),
    .in_ready  (buf_in_ready),
    .in_data   (state.word),
    .out_valid (tx_valid),
    .out_ready (tx_ready),
    .out_data  (buf_out_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  // Both devices see the same register, so they change in the same cycle.
  assign adc_speed_mode_sel        = state.speed;
  assign adc_format_sel            = state.format;
  assign adc_mclk_half_div         = state.half_div;
  assign adc_mclk_three_halves_div = state.three_halves;
  assign tx_speed_mode_sel         = state.speed;
  assign tx_mclk_half_div          = state.half_div;
  assign tx_mclk_three_halves_div  = state.three_halves;
  assign tx_lane_data              = state.lane_data;
  assign tx_left                   = buf_out_data[WORD_W-1:`SAMPLE_BITS];
  assign tx_right                  = buf_out_data[`SAMPLE_BITS-1:0];
  assign dsp_sclk                  = state.dsp_pins[PIN_W-1];
  assign dsp_lrck                  = state.dsp_pins[PIN_W-2];
  assign dsp_data                  = state.dsp_pins[`LANES-1:0];
  assign frame_aligned             = state.aligned;
  assign overrun                   = state.overrun;

endmodule // adc_board_audio_router

// *** rtl/two_entry_buffer.sv ***
// Small valid/ready buffer that absorbs a stall by the receiver.
`timescale 1ns/100ps
module two_entry_buffer #(
  parameter int WIDTH = 48,
  parameter int DEPTH = 2
) (
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire logic             in_valid,
  output      logic             in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output      logic             out_valid,
  input  wire logic             out_ready,
  output      logic [WIDTH-1:0] out_data
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin
      $error("two_entry_buffer: DEPTH must be a power of two >= 2");
    end
  end

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0]               wr_ptr;
    logic [PW-1:0]               rd_ptr;
    logic [PW:0]                 count;
  } buf_state_t;

  buf_state_t state;
  buf_state_t next_state;
  logic       push;
  logic       pop;

  assign in_ready  = (state.count != DEPTH[PW:0]);
  assign out_valid = (state.count != '0);
  assign out_data  = state.mem[state.rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    next_state = state;
    if (push) begin
      next_state.mem[state.wr_ptr] = in_data;
      next_state.wr_ptr = state.wr_ptr + 1'b1;
    end
    if (pop) begin
      next_state.rd_ptr = state.rd_ptr + 1'b1;
    end
    if (push && !pop) begin
      next_state.count = state.count + 1'b1;
    end else if (pop && !push) begin
      next_state.count = state.count - 1'b1;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

endmodule // two_entry_buffer

// *** shared/audio_router_defs.svh ***
// Constants for the board audio routing and configuration logic.
`ifndef AUDIO_ROUTER_DEFS_SVH
`define AUDIO_ROUTER_DEFS_SVH

// Field positions in the six-switch configuration bank.
`define SWA_PAIR_LO       0
`define SWA_PAIR_HI       1
`define SWA_FORMAT_LO     2
`define SWA_FORMAT_HI     3
`define SWA_SPEED_LO      4
`define SWA_SPEED_HI      5
`define SWA_WIDTH         6

// Field positions in the two-switch clock bank.
`define SWB_HALF_DIV      0
`define SWB_THREE_HALVES  1
`define SWB_WIDTH         2

// Serial frame geometry.
`define SAMPLE_BITS       24
`define SLOT_BITS         32
`define TDM_SLOTS         8
`define LANES             4
`define BIT_CNT_W         8

// Reset values of the configuration outputs.
`define RST_SPEED         2'h0
`define RST_FORMAT        2'h0
`define RST_PAIR          2'h0

// Two-entry buffer depth.
`define BUF_DEPTH         2

`endif

// *** shared/audio_router_pkg.sv ***
// Types shared by the board audio routing and configuration logic.
package audio_router_pkg;

  typedef enum logic [1:0] {
    SPEED_SINGLE_MASTER = 2'h0,
    SPEED_DOUBLE_MASTER = 2'h1,
    SPEED_QUAD_MASTER   = 2'h2,
    SPEED_SLAVE_ANY     = 2'h3
  } speed_mode_t;

  typedef enum logic [1:0] {
    FORMAT_LEFT_JUST = 2'h0,
    FORMAT_I2S       = 2'h1,
    FORMAT_TDM_2WIRE = 2'h2,
    FORMAT_TDM_4WIRE = 2'h3
  } format_t;

endpackage

// *** verif/adc_board_audio_router_props.sv ***
// Concurrent checks on the router's configuration and hand-off ports.
`timescale 1ns/100ps
module adc_board_audio_router_props (
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic [5:0]  switch_bank_a,
  input wire logic [1:0]  switch_bank_b,
  input wire logic        host_ctrl_en,
  input wire logic [1:0]  host_speed_mode_sel,
  input wire logic [1:0]  host_format_sel,
  input wire logic        host_mclk_half_div,
  input wire logic        host_mclk_three_halves_div,
  input wire logic [1:0]  adc_speed_mode_sel,
  input wire logic [1:0]  adc_format_sel,
  input wire logic        adc_mclk_half_div,
  input wire logic        adc_mclk_three_halves_div,
  input wire logic [1:0]  tx_speed_mode_sel,
  input wire logic        tx_mclk_half_div,
  input wire logic        tx_mclk_three_halves_div,
  input wire logic        tx_valid,
  input wire logic        tx_ready,
  input wire logic [23:0] tx_left,
  input wire logic [23:0] tx_right
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  // Switches must sit still through both sync stages and the config register.
  sequence s_sw_quiet;
    (!host_ctrl_en && $stable(switch_bank_a) && $stable(switch_bank_b))[*5];
  endsequence
  sequence s_host_held;
    !$past(rst) && $past(host_ctrl_en);
  endsequence
  property p_cfg_pair;
    adc_speed_mode_sel == tx_speed_mode_sel &&
      adc_mclk_half_div == tx_mclk_half_div &&
      adc_mclk_three_halves_div == tx_mclk_three_halves_div;
  endproperty
  property p_sw_mode;
    s_sw_quiet |-> adc_speed_mode_sel == switch_bank_a[5:4];
  endproperty
  property p_sw_fmt;
    s_sw_quiet |-> adc_format_sel == switch_bank_a[3:2];
  endproperty
  property p_sw_div;
    s_sw_quiet |-> adc_mclk_half_div == switch_bank_b[0] &&
      adc_mclk_three_halves_div == switch_bank_b[1];
  endproperty
  property p_host_mode;
    s_host_held |-> adc_speed_mode_sel == $past(host_speed_mode_sel);
  endproperty
  property p_host_fmt;
    s_host_held |-> adc_format_sel == $past(host_format_sel);
  endproperty
  property p_host_div;
    s_host_held |-> adc_mclk_half_div == $past(host_mclk_half_div) &&
      adc_mclk_three_halves_div == $past(host_mclk_three_halves_div);
  endproperty
  property p_tx_hold;
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_left) &&
      $stable(tx_right);
  endproperty
  a_cfg_pair: assert property (p_cfg_pair)
    else $error("converter and transmitter settings differ");
  a_sw_mode: assert property (p_sw_mode)
    else $error("speed mode does not follow switches");
  a_sw_fmt: assert property (p_sw_fmt)
    else $error("format does not follow switches");
  a_sw_div: assert property (p_sw_div)
    else $error("clock dividers do not follow switches");
  a_host_mode: assert property (p_host_mode)
    else $error("speed mode does not follow host");
  a_host_fmt: assert property (p_host_fmt)
    else $error("format does not follow host");
  a_host_div: assert property (p_host_div)
    else $error("clock dividers do not follow host");
  a_tx_hold: assert property (p_tx_hold)
    else $error("stalled output word changed");
endmodule // adc_board_audio_router_props

bind adc_board_audio_router adc_board_audio_router_props chk_u (
  .clk_sys, .rst, .switch_bank_a, .switch_bank_b, .host_ctrl_en,
  .host_speed_mode_sel, .host_format_sel, .host_mclk_half_div,
  .host_mclk_three_halves_div, .adc_speed_mode_sel, .adc_format_sel,
  .adc_mclk_half_div, .adc_mclk_three_halves_div, .tx_speed_mode_sel,
  .tx_mclk_half_div, .tx_mclk_three_halves_div, .tx_valid, .tx_ready,
  .tx_left, .tx_right
);

// *** verif/adc_serial_model.sv ***
// Converter-side source of left-justified, I2S or TDM frames, back to back.
`timescale 1ns/100ps
module adc_serial_model (
  input  wire logic        tdm,
  input  wire logic        i2s,
  input  wire logic [1:0]  pair,
  input  wire logic [47:0] word,
  output      logic        sclk,
  output      logic        lrck,
  output      logic [3:0]  lanes,
  output      logic [47:0] sent_word,
  output      logic [15:0] frame_no,
  output      logic        sent_tgl
);
  logic       t;
  logic [1:0] p;
  logic       d;
  logic       i;
  int         kk;
  int         ls;
  int         k;
  int         slot;
  // Settings are latched at frame start, as a real converter would apply them.
  initial begin
    sclk = 1'b0;
    sent_tgl = 1'b0;
    frame_no = 16'h0;
    d = 1'b0;
    forever begin
      t = tdm;
      p = pair;
      i = i2s;
      sent_word = word;
      frame_no = frame_no + 16'h1;
      ls = t ? 2 * p : 0;
      for (int b = 0; b < (t ? 256 : 64); b++) begin
        slot = b / 32;
        k = b % 32;
        // I2S starts left on a low level and delays data by one bit.
        lrck = (b < 32) ^ i;
        kk = k - int'(i);
        if (slot == ls && kk >= 0 && kk < 24) d = sent_word[47 - kk];
        else if (slot == ls + 1 && kk >= 0 && kk < 24) d = sent_word[23 - kk];
        else d = ~d;
        // Idle lanes carry the inverse so a wrong lane choice shows.
        lanes = {4{~d}};
        lanes[t ? 0 : p] = d;
        #16 sclk = 1'b1;
        if (slot == ls + 1 && kk == 23) sent_tgl = ~sent_tgl;
        #16 sclk = 1'b0;
      end
    end
  end
endmodule // adc_serial_model

// *** verif/tb_adc_board_audio_router.sv ***
// Self-checking bench for the board audio router.
`timescale 1ns/100ps
module tb_adc_board_audio_router;
  logic        clk_sys = 1'b0;
  logic        rst, host_ctrl_en, host_mclk_half_div, tx_ready, stall;
  logic        host_mclk_three_halves_div, adc_sclk, adc_lrck, tdm, i2s;
  logic        adc_mclk_half_div, adc_mclk_three_halves_div, tx_lane_data;
  logic        tx_mclk_half_div, tx_mclk_three_halves_div, tx_valid;
  logic        dsp_sclk, dsp_lrck, frame_aligned, overrun, ovr_seen, sent_tgl;
  logic [5:0]  switch_bank_a;
  logic [1:0]  switch_bank_b, host_speed_mode_sel, host_format_sel, pair;
  logic [1:0]  host_pair_sel, adc_speed_mode_sel, adc_format_sel;
  logic [1:0]  tx_speed_mode_sel;
  logic [3:0]  serial_out_lane, dsp_data, lv;
  logic [23:0] tx_left, tx_right;
  logic [47:0] word, sent_word;
  logic [15:0] frame_no, chg_no;
  logic [47:0] exp_q[$];
  int          err_total = 0;
  int          compares = 0;

  adc_board_audio_router dut_u (.clk_sys, .rst, .switch_bank_a,
    .switch_bank_b, .host_ctrl_en, .host_speed_mode_sel, .host_format_sel,
    .host_pair_sel, .host_mclk_half_div, .host_mclk_three_halves_div,
    .adc_sclk, .adc_lrck, .serial_out_lane, .adc_speed_mode_sel,
    .adc_format_sel, .adc_mclk_half_div, .adc_mclk_three_halves_div,
    .tx_speed_mode_sel, .tx_mclk_half_div, .tx_mclk_three_halves_div,
    .tx_lane_data, .tx_valid, .tx_ready, .tx_left, .tx_right, .dsp_sclk,
    .dsp_lrck, .dsp_data, .frame_aligned, .overrun);
  adc_serial_model conv_u (.tdm, .i2s, .pair, .word, .sclk(adc_sclk),
    .lrck(adc_lrck), .lanes(serial_out_lane), .sent_word, .frame_no,
    .sent_tgl);

  always #2 clk_sys = ~clk_sys;

  ////////////////////////////////////////////////////////////////////////
  task automatic check(string name, logic [47:0] seen, logic [47:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic test_done();
    if (err_total == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic step(int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic cfg_chk(logic [5:0] e);
    check("adc_cfg", {adc_speed_mode_sel, adc_format_sel, adc_mclk_half_div,
      adc_mclk_three_halves_div}, e);
    check("tx_cfg", {tx_speed_mode_sel, tx_mclk_half_div,
      tx_mclk_three_halves_div}, {e[5:4], e[1:0]});
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Only frames begun after the last setting change may reach the output.
  always @(sent_tgl) begin
    if (chg_no != 16'hFFFF && frame_no > chg_no) exp_q.push_back(sent_word);
    word = {24'($urandom), 24'($urandom)};
  end

  always @(posedge clk_sys) begin
    if (overrun === 1'b1) ovr_seen <= 1'b1;
    if (tx_valid === 1'b1 && tx_ready === 1'b1 && chg_no != 16'hFFFF) begin
      if (exp_q.size() == 0) check("tx_extra", 48'h1, 48'h0);
      else check("tx_word", {tx_left, tx_right}, exp_q.pop_front());
    end
  end

  always @(posedge clk_sys) begin
    #1;
    tx_ready = !stall && 1'($urandom);
  end

  initial begin
    #300000;
    err_total++;
    test_done();
  end

  ////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'hA90708BB));
    {rst, stall, ovr_seen, tdm, pair, chg_no} = {3'h4, 3'h0, 16'h1};
    {switch_bank_a, switch_bank_b, host_ctrl_en, i2s} = 10'h000;
    {host_speed_mode_sel, host_format_sel, host_pair_sel} = 6'h00;
    {host_mclk_half_div, host_mclk_three_halves_div} = 2'h0;
    word = 48'hA5A5A5_5A5A5A;
    step(4);
    cfg_chk(6'h00);
    step(4);
    rst = 1'b0;
    chg_no = 16'hFFFF;
    for (int i = 0; i < 4; i++) begin
      switch_bank_a = {2'(i), ~2'(i), 2'($urandom)};
      switch_bank_b = 2'(i);
      step(5);
      cfg_chk({switch_bank_a[5:2], switch_bank_b[0],
        switch_bank_b[1]});
    end
    host_ctrl_en = 1'b1;
    {host_speed_mode_sel, host_format_sel, host_mclk_half_div,
      host_mclk_three_halves_div} = 6'($urandom);
    step(2);
    switch_bank_a = ~switch_bank_a;
    switch_bank_b = ~switch_bank_b;
    step(6);
    cfg_chk({host_speed_mode_sel, host_format_sel, host_mclk_half_div,
      host_mclk_three_halves_div});
    host_ctrl_en = 1'b0;
    for (int ph = 0; ph < 8; ph++) begin
      @(sent_tgl);
      step(20);
      // The source switches together with the format, before TDM runs.
      tdm = (ph >= 4);
      pair = 2'(ph);
      i2s = !tdm && (ph == 2);
      switch_bank_a = {2'h0, tdm, tdm ? pair[0] : i2s, pair};
      // Entering or leaving I2S shows no frame edge at the first new
      // frame start, so that frame cannot align and is not expected.
      chg_no = frame_no + 16'((ph == 2) || (ph == 3));
      repeat (3) @(sent_tgl);
      @(posedge adc_sclk);
      lv = serial_out_lane;
      step(4);
      check("tx_lane_data", tx_lane_data, lv[pair]);
      check("dsp_data", dsp_data, lv);
    end
    @(sent_tgl);
    step(20);
    stall = 1'b1;
    ovr_seen = 1'b0;
    repeat (3) @(sent_tgl);
    step(20);
    check("overrun", ovr_seen, 1'b1);
    exp_q.delete(2);
    stall = 1'b0;
    repeat (2) @(sent_tgl);
    step(20);
    check("words_left", 48'(exp_q.size()), 48'h0);
    test_done();
  end
endmodule // tb_adc_board_audio_router
